// File: hdl/dpi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module dpi_ctrl (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	// axi4-lite write address
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [dpi_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	// axi4-lite write data
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	input  wire logic [dpi_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	// axi4-lite write response
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	output logic [1:0]                     s_axi_bresp,
	// axi4-lite read address
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	input  wire logic [dpi_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	// axi4-lite read data
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	output logic [dpi_pkg::DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	// module state, same clock
	input  wire dpi_pkg::dpi_mod_state_t   mod_state,
	// data path control outputs
	output logic [dpi_pkg::LANES-1:0]      path_bringup_req,
	output logic [dpi_pkg::LANES-1:0]      path_teardown_req,
	output logic [dpi_pkg::LANES-1:0]      path_start_pulse,
	// base page advertisement
	output logic [7:0]                     base_adv_byte2
);

	//==========================================================
	// declarations
	logic                      aw_held_ff, nxt_aw_held;
	logic [dpi_pkg::ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
	logic                      w_held_ff, nxt_w_held;
	logic [dpi_pkg::DATA_W-1:0] w_data_ff, nxt_w_data;
	logic [3:0]                w_strb_ff, nxt_w_strb;
	logic                      bvalid_ff, nxt_bvalid;
	logic [1:0]                bresp_ff, nxt_bresp;
	logic                      rvalid_ff, nxt_rvalid;
	logic [dpi_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [1:0]                rresp_ff, nxt_rresp;
	logic [7:0]                teardown_ff, nxt_teardown;
	logic [3:0]                app_code_ff, nxt_app_code;
	logic [7:0]                bringup_ff, nxt_bringup;
	logic [7:0]                tear_req_ff, nxt_tear_req;
	logic [7:0]                start_ff, nxt_start;
	logic [7:0]                eff_tear;
	logic                      mismatch;
	logic [2:0]                span;
	logic                      oper;
	logic                      do_write;
	logic                      w_ok;
	logic [dpi_pkg::DATA_W-1:0] rd_val;
	logic                      rd_ok;

	//==========================================================
	// bus outputs
	assign s_axi_awready  = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready   = !w_held_ff && !bvalid_ff;
	assign s_axi_arready  = !rvalid_ff;
	assign s_axi_bvalid   = bvalid_ff;
	assign s_axi_bresp    = bresp_ff;
	assign s_axi_rvalid   = rvalid_ff;
	assign s_axi_rdata    = rdata_ff;
	assign s_axi_rresp    = rresp_ff;
	assign path_bringup_req  = bringup_ff;
	assign path_teardown_req = tear_req_ff;
	assign path_start_pulse  = start_ff;

	// page is present: flag in base page byte 2
	assign base_adv_byte2 = 8'h01 << dpi_pkg::BASE_ADV_BIT;

	//==========================================================
	// write decode: only the teardown byte and code word are writable here
	always_comb begin
		w_ok = 1'b0;
		if (aw_addr_ff == dpi_pkg::OFS_TEARDOWN) begin
			w_ok = 1'b1;
		end else if (aw_addr_ff == dpi_pkg::OFS_APP_CODE) begin
			w_ok = 1'b1;
		end
	end

	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

	//==========================================================
	// write channel: hold address and data in either order
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held  = w_held_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			nxt_aw_held = 1'b0;
			nxt_w_held  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = w_ok ? dpi_pkg::RESP_OKAY : dpi_pkg::RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
			w_held_ff  <= 1'b0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= dpi_pkg::RESP_OKAY;
		end else begin
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff  <= nxt_w_held;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
		end
	end

	//==========================================================
	// control registers, kept regardless of module state
	always_comb begin
		nxt_teardown = teardown_ff;
		nxt_app_code = app_code_ff;
		if (do_write && w_strb_ff[0]) begin
			if (aw_addr_ff == dpi_pkg::OFS_TEARDOWN) begin
				nxt_teardown = w_data_ff[7:0];
			end else if (aw_addr_ff == dpi_pkg::OFS_APP_CODE) begin
				nxt_app_code = w_data_ff[3:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			teardown_ff <= dpi_pkg::RST_TEARDOWN;
			app_code_ff <= dpi_pkg::RST_APP_CODE;
		end else begin
			teardown_ff <= nxt_teardown;
			app_code_ff <= nxt_app_code;
		end
	end

	//==========================================================
	// lane grouping: any lane set in a path tears the path down
	assign span = dpi_pkg::SPAN_BY_CODE[{app_code_ff, 2'b00} +: 3];

	always_comb begin
		eff_tear = '0;
		mismatch = 1'b0;
		for (int i = 0; i < dpi_pkg::LANES; i++) begin
			for (int j = 0; j < dpi_pkg::LANES; j++) begin
				if ((3'(j) & ~span) == (3'(i) & ~span)) begin
					eff_tear[i] = eff_tear[i] | teardown_ff[j];
					mismatch    = mismatch | (teardown_ff[j] != teardown_ff[i]);
				end
			end
		end
	end

	assign oper = (mod_state == dpi_pkg::MOD_OPERATIONAL);

	//==========================================================
	// path requests, all lanes evaluated together
	always_comb begin
		nxt_bringup  = '0;
		nxt_tear_req = '0;
		if (oper) begin
			nxt_bringup  = ~eff_tear;
			nxt_tear_req = eff_tear;
		end
		nxt_start = nxt_bringup & ~bringup_ff;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bringup_ff  <= '0;
			tear_req_ff <= '0;
			start_ff    <= '0;
		end else begin
			bringup_ff  <= nxt_bringup;
			tear_req_ff <= nxt_tear_req;
			start_ff    <= nxt_start;
		end
	end

	//==========================================================
	// read decode over the page areas
	always_comb begin
		rd_val = '0;
		rd_ok  = 1'b0;
		if (s_axi_araddr == dpi_pkg::OFS_TEARDOWN) begin
			rd_val = {24'h000000, teardown_ff};
			rd_ok  = 1'b1;
		end else if (s_axi_araddr == dpi_pkg::OFS_APP_CODE) begin
			rd_val = {28'h0000000, app_code_ff};
			rd_ok  = 1'b1;
		end else if (s_axi_araddr == dpi_pkg::OFS_STATUS) begin
			rd_val[7:0]                  = bringup_ff;
			rd_val[15:8]                 = tear_req_ff;
			rd_val[dpi_pkg::STS_OPER_BIT] = oper;
			rd_val[dpi_pkg::STS_MISM_BIT] = mismatch;
			rd_ok  = 1'b1;
		end else if (s_axi_araddr >= dpi_pkg::OFS_RSVD_LO && s_axi_araddr <= dpi_pkg::OFS_RSVD_HI) begin
			rd_ok  = 1'b1;
		end
		// lane, staged set and mask areas belong to other blocks: error
	end

	// read channel
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_val;
			nxt_rresp  = rd_ok ? dpi_pkg::RESP_OKAY : dpi_pkg::RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= '0;
			rresp_ff  <= dpi_pkg::RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
	end

endmodule : dpi_ctrl

`default_nettype wire

// File: hdl/dpi_pkg.sv
//==========================================================
// data path init control: shared constants
package dpi_pkg;

	//==========================================================
	// bus geometry
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          LANES         = 8;

	//==========================================================
	// control page layout, byte offsets
	localparam logic [7:0]  OFS_TEARDOWN  = 8'h80;  // byte 128
	localparam logic [7:0]  OFS_LANE_LO   = 8'h81;  // 129
	localparam logic [7:0]  OFS_LANE_HI   = 8'h8e;  // 142
	localparam logic [7:0]  OFS_SET0_LO   = 8'h8f;  // 143
	localparam logic [7:0]  OFS_SET0_HI   = 8'hb1;  // 177
	localparam logic [7:0]  OFS_SET1_LO   = 8'hb2;  // 178
	localparam logic [7:0]  OFS_SET1_HI   = 8'hd4;  // 212
	localparam logic [7:0]  OFS_MASK_LO   = 8'hd5;  // 213
	localparam logic [7:0]  OFS_MASK_HI   = 8'he7;  // 231
	localparam logic [7:0]  OFS_RSVD_LO   = 8'he8;  // 232
	localparam logic [7:0]  OFS_RSVD_HI   = 8'hef;  // 239
	localparam logic [7:0]  OFS_CUST_LO   = 8'hf0;  // 240
	localparam logic [7:0]  OFS_APP_CODE  = 8'hf0;  // applied selection code
	localparam logic [7:0]  OFS_STATUS    = 8'hf4;  // path status

	//==========================================================
	// reset values and fields
	localparam logic [7:0]  RST_TEARDOWN  = 8'h00;  // all paths auto-initialise
	localparam logic [3:0]  RST_APP_CODE  = 4'h0;
	localparam int          STS_OPER_BIT  = 16;
	localparam int          STS_MISM_BIT  = 17;
	localparam int          BASE_ADV_BIT  = 7;      // base page byte 2 bit

	// lane span mask (lanes per path minus one) by selection code, 4 bits each
	localparam logic [63:0] SPAN_BY_CODE  = 64'h7310_7310_7310_7310;

	//==========================================================
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// module state from the module state machine
	typedef enum logic [1:0] {
		MOD_SLEEP       = 2'h0,
		MOD_BOOT        = 2'h1,
		MOD_OPERATIONAL = 2'h3,
		MOD_FAULT       = 2'h2
	} dpi_mod_state_t;

endpackage : dpi_pkg

// File: test/dpi_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module dpi_ctrl_assertions (
	// clock and reset
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	// bus handshakes
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic [31:0]             s_axi_rdata,
	// path side
	input wire dpi_pkg::dpi_mod_state_t mod_state,
	input wire logic [7:0]              path_bringup_req,
	input wire logic [7:0]              path_teardown_req,
	input wire logic [7:0]              path_start_pulse,
	input wire logic [7:0]              base_adv_byte2
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	//==========================================================
	// path outputs
	idle_no_path_a: assert property (mod_state != dpi_pkg::MOD_OPERATIONAL |=>
		(path_bringup_req | path_teardown_req) == 8'h00) else $error("path request outside operational");
	req_complement_a: assert property (mod_state == dpi_pkg::MOD_OPERATIONAL |=>
		(path_bringup_req ^ path_teardown_req) == 8'hff) else $error("bringup and teardown not complementary");
	start_single_a: assert property (path_start_pulse != 8'h00 |=>
		(path_start_pulse & $past(path_start_pulse)) == 8'h00) else $error("start pulse longer than one cycle");
	adv_flag_a: assert property (base_adv_byte2 == 8'h80) else $error("page presence flag wrong");
	start_edge_a: assert property (path_start_pulse == (path_bringup_req & ~$past(path_bringup_req)))
		else $error("start pulse not on bringup rise");

	//==========================================================
	// register bus
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken during response");
	ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during data");
endmodule : dpi_ctrl_assertions

`default_nettype wire

// File: test/dpi_host.sv
`timescale 1ns/1ps
`default_nettype none

module dpi_host (
	// clock
	input  wire logic  clk_sys,
	// write channels
	output logic       s_axi_awvalid,
	input  wire logic  s_axi_awready,
	output logic [7:0] s_axi_awaddr,
	output logic       s_axi_wvalid,
	input  wire logic  s_axi_wready,
	output logic [31:0] s_axi_wdata,
	input  wire logic  s_axi_bvalid,
	output logic       s_axi_bready,
	// read channels
	output logic       s_axi_arvalid,
	input  wire logic  s_axi_arready,
	output logic [7:0] s_axi_araddr,
	input  wire logic  s_axi_rvalid,
	output logic       s_axi_rready
);
	// idle bus at time zero
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	end

	// one write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	// one read
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : dpi_host

`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, path_bringup_req, path_teardown_req, path_start_pulse, base_adv_byte2;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pulse_seen = 8'h00;
	logic [7:0] v;
	dpi_pkg::dpi_mod_state_t mod_state;
	logic [33:0] exp_q[$];
	int miscompares, n_checks, cyc;

	dpi_ctrl dut_u (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mod_state, .path_bringup_req, .path_teardown_req,
		.path_start_pulse, .base_adv_byte2);
	dpi_host host_u (.clk_sys, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
		.s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready);

	task automatic stop_test;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// note the expected answer, then drive the bus
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		exp_q.push_back({rs, 32'h0});
		host_u.wr(a, d);
	endtask : w
	task automatic r(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		exp_q.push_back({rs, d});
		host_u.rd(a);
	endtask : r
	task automatic paths(input logic [7:0] td, input logic [7:0] br);
		repeat (3) @(posedge clk_sys);
		#1;
		chk("teardown_req", 34'(path_teardown_req), 34'(td));
		chk("bringup_req", 34'(path_bringup_req), 34'(br));
	endtask : paths
	task automatic set_state(input dpi_pkg::dpi_mod_state_t s);
		@(posedge clk_sys) mod_state <= s;
	endtask : set_state

	// equal bits across each path of 2**c lanes
	function automatic logic [7:0] spread(input logic [7:0] x, input int c);
		int wd;
		wd = 1 << c;
		for (int i = 0; i < 8; i++) spread[i] = |(x & (8'((1 << wd) - 1) << (i / wd * wd)));
	endfunction : spread
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// response monitor, timeout and pulse capture
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		pulse_seen <= pulse_seen | path_start_pulse;
		if (s_axi_bvalid && s_axi_bready && exp_q.size() > 0) chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		// timeout last: nothing may follow the finish in this process
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		mod_state = dpi_pkg::MOD_SLEEP;
		seed = 32'h87139f1f;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		r(8'h80, 32'h0, dpi_pkg::RESP_OKAY);
		r(8'he8, 32'h0, dpi_pkg::RESP_OKAY);
		r(8'h81, 32'h0, dpi_pkg::RESP_SLVERR);
		w(8'hd5, 32'h1, dpi_pkg::RESP_SLVERR);
		paths(8'h00, 8'h00);
		chk("adv_flag", 34'(base_adv_byte2), 34'h80);
		set_state(dpi_pkg::MOD_OPERATIONAL);
		paths(8'h00, 8'hff);
		chk("start_pulse", 34'(pulse_seen), 34'hff);
		for (int s = 0; s < 3; s++) begin
			set_state(dpi_pkg::dpi_mod_state_t'(s));
			w(8'h80, 32'hff, dpi_pkg::RESP_OKAY);
			r(8'h80, 32'hff, dpi_pkg::RESP_OKAY);
			paths(8'h00, 8'h00);
		end
		set_state(dpi_pkg::MOD_OPERATIONAL);
		paths(8'hff, 8'h00);
		w(8'h80, 32'h0, dpi_pkg::RESP_OKAY);
		paths(8'h00, 8'hff);
		for (int c = 0; c < 4; c++) begin
			seed = lfsr(seed);
			v = spread(seed[7:0], c);
			w(8'hf0, 32'(c), dpi_pkg::RESP_OKAY);
			w(8'h80, {24'h0, v}, dpi_pkg::RESP_OKAY);
			paths(v, ~v);
			r(8'hf4, {14'h0, 2'b01, v, ~v}, dpi_pkg::RESP_OKAY);
		end
		// host fault: lanes of one two-lane path disagree, the whole path goes down
		w(8'hf0, 32'h1, dpi_pkg::RESP_OKAY);
		w(8'h80, 32'h1, dpi_pkg::RESP_OKAY);
		paths(8'h03, 8'hfc);
		r(8'hf4, {14'h0, 2'b11, 8'h03, 8'hfc}, dpi_pkg::RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		stop_test();
	end
endmodule : testbench

bind dpi_ctrl dpi_ctrl_assertions chk_u (.clk_sys, .rst_n, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mod_state, .path_bringup_req,
	.path_teardown_req, .path_start_pulse, .base_adv_byte2);

`default_nettype wire
